// *** verilog/odfc_pkg.sv ***
// Constants for the output driver fault control block.
// Assumes a 20 MHz system clock and AXI4-Lite access with 8-bit registers.
package odfc_pkg;

  // Clock rate
  localparam int CLK_MHZ = 20;

  // Register indices; byte address is four times the index
  localparam logic [9:0] PAGE1_BASE   = 10'h080;
  localparam logic [9:0] IDX_SW_RESET = 10'h001;
  localparam logic [9:0] IDX_OTP      = 10'h003;
  localparam logic [9:0] IDX_STEP     = 10'h03f;
  localparam logic [9:0] IDX_HP_CTRL  = PAGE1_BASE + 10'h01f;
  localparam logic [9:0] IDX_SPK_CTRL = PAGE1_BASE + 10'h020;
  localparam logic [9:0] IDX_ROUTE    = PAGE1_BASE + 10'h023;
  localparam logic [9:0] IDX_SPK_VOL  = PAGE1_BASE + 10'h026;
  localparam logic [9:0] IDX_HPL_GAIN = PAGE1_BASE + 10'h028;
  localparam logic [9:0] IDX_HPR_GAIN = PAGE1_BASE + 10'h029;
  localparam logic [9:0] IDX_SPK_GAIN = PAGE1_BASE + 10'h02a;
  localparam logic [9:0] IDX_DRIVE    = PAGE1_BASE + 10'h02c;

  // Field positions
  localparam int BIT_LEFT_EN    = 7;
  localparam int BIT_RIGHT_EN   = 6;
  localparam int BIT_SPK_EN     = 7;
  localparam int BIT_SC_MODE    = 1;
  localparam int BIT_STATUS     = 0;
  localparam int BIT_OTP        = 1;
  localparam int CM_LSB         = 3;
  localparam int BIT_ROUTE_L    = 6;
  localparam int BIT_ROUTE_R    = 2;
  localparam int BIT_VOL_ROUTE  = 7;
  localparam int GAIN_LSB       = 3;
  localparam int BIT_UNMUTE     = 2;
  localparam int DRIVE_LSB      = 1;

  // Reset values
  localparam logic [7:0] RST_DEFAULT = 8'h00;
  localparam logic [7:0] RST_SPK_VOL = 8'h7f;
  localparam logic [6:0] ATTEN_MUTE  = 7'h7f;
  localparam logic [1:0] DRIVE_LINEOUT = 2'h3;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Soft-step pacing codes
  typedef enum logic [1:0] {
    ODFC_STEP_ONE = 2'b00,
    ODFC_STEP_TWO = 2'b01,
    ODFC_STEP_OFF = 2'b10,
    ODFC_STEP_RSV = 2'b11
  } odfc_step_t;

  // Soft-step and soft-start times
  localparam int STEP_ONE_NS   = 20800;
  localparam int STEP_TWO_NS   = 41600;
  localparam int SOFTSTART_NS  = 10000;
  localparam logic [9:0] STEP_ONE_CYC =
    10'((STEP_ONE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [9:0] STEP_TWO_CYC =
    10'((STEP_TWO_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] SOFTSTART_CYC =
    8'((SOFTSTART_NS * CLK_MHZ + 999) / 1000);

endpackage : odfc_pkg

// *** verilog/odfc_step_if.sv ***
// Carrier between the control logic and the volume soft-stepper.
// Assumes both ends run on the same system clock.
`timescale 1ns/10ps
interface odfc_step_if;
  logic [6:0]          target;
  odfc_pkg::odfc_step_t pace;
  logic [6:0]          current;
  logic                busy;

  modport ctrl    (output target, output pace, input current, input busy);
  modport stepper (input target, input pace, output current, output busy);
endinterface : odfc_step_if

// *** verilog/odfc_soft_stepper.sv ***
// Soft-stepping attenuation ramp: moves one 0.5 dB code per pacing period.
// Assumes the target comes from a register on the same clock.
`timescale 1ns/10ps
module odfc_soft_stepper (
  input  wire logic clk,
  input  wire logic rst,
  odfc_step_if.stepper stp
);

  logic [9:0] timer;

  // Period counter restarts on each step
  always_ff @(posedge clk)
  begin
    if (rst)
      timer <= 10'h000;
    else if (stp.current == stp.target || timer == 10'h000)
      timer <= (stp.pace == odfc_pkg::ODFC_STEP_TWO) ? odfc_pkg::STEP_TWO_CYC
                                                     : odfc_pkg::STEP_ONE_CYC;
    else
      timer <= timer - 10'h001;
  end

  // Current code chases the target, stepping or jumping
  always_ff @(posedge clk)
  begin
    if (rst)
      stp.current <= odfc_pkg::ATTEN_MUTE;
    else if (stp.current != stp.target)
    begin
      if (stp.pace == odfc_pkg::ODFC_STEP_OFF || stp.pace == odfc_pkg::ODFC_STEP_RSV)
        stp.current <= stp.target;
      else if (timer == 10'h000)
        stp.current <= (stp.current < stp.target) ? stp.current + 7'h01
                                                  : stp.current - 7'h01;
    end
  end

  // Busy while a ramp is under way
  always_ff @(posedge clk)
  begin
    if (rst)
      stp.busy <= 1'b0;
    else
      stp.busy <= (stp.current != stp.target);
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_step_jump;
    (stp.pace == odfc_pkg::ODFC_STEP_OFF) && stp.current != stp.target
      && $stable(stp.target) |=> stp.current == $past(stp.target);
  endproperty
  a_step_jump: assert property (p_step_jump) else $error("jump pacing missed target");

  property p_step_single;
    (stp.pace == odfc_pkg::ODFC_STEP_ONE) && $stable(stp.pace) && $changed(stp.current)
      |=> $stable(stp.current);
  endproperty
  a_step_single: assert property (p_step_single) else $error("step came too soon");

endmodule : odfc_soft_stepper

// *** verilog/odfc_output_driver_fault_control.sv ***
// Output driver control and short-circuit / over-temperature protection.
// Assumes an AXI4-Lite master on clk and asynchronous fault detector levels.
// Function
// - Speaker attenuation seven bits, soft-stepped
// - Speaker amp fed only while routing bit set
// - Left DAC routed by dedicated routing bit
// - Two-bit field paces soft-stepping
// - Drive code 11 selects low-power lineout
// - Two-bit common-mode level select
// - Separate left and right headphone enables
// - Headphone gain and mute per side
// - Short: limit current or shut down
// - Headphone short shown in status bit
// - Shutdown clears affected headphone enable immediately
// - Status cleared by master reset or enable set; master reset also clears enables
// - Speaker gain and mute fields
// - Speaker overcurrent always shuts stage down
// - Speaker short shown in status bit
// - Setting speaker enable re-arms stage
// - Over-temperature stops switching, shown as flag
// - Stages soft-start, each timed from its own enable
// - Speaker enable bit powers class-D drivers
// - Mute when unrouted and attenuation all ones
`timescale 1ns/10ps
module odfc_output_driver_fault_control (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        leftHpShortIn,
  input  wire logic        rightHpShortIn,
  input  wire logic        speakerShortIn,
  input  wire logic        overTempIn,
  output logic             leftHeadphoneOutOn,
  output logic             rightHeadphoneOutOn,
  output logic             speakerOutOn,
  output logic             speakerSwitchEn,
  output logic             hpCurrentLimit,
  output logic [2:0]       softStartActive,
  output logic [1:0]       commonModeSel,
  output logic             lineoutLowPower,
  output logic             dacLeftToVolume,
  output logic             dacRightToVolume,
  output logic             speakerVolToAmp,
  output logic [6:0]       speakerAtten,
  output logic             speakerVolMute,
  output logic [3:0]       leftHpGain,
  output logic             leftHpMute,
  output logic [3:0]       rightHpGain,
  output logic             rightHpMute,
  output logic [1:0]       speakerGain,
  output logic             speakerMute
);

  // Control registers
  logic [7:0] stepReg;
  logic [7:0] hpCtrl;
  logic [7:0] spkCtrl;
  logic [7:0] routeReg;
  logic [7:0] spkVol;
  logic [7:0] hplGainReg;
  logic [7:0] hprGainReg;
  logic [7:0] spkGainReg;
  logic [7:0] driveReg;
  logic       softReset;
  logic       regReset;
  // Bus state
  logic       awHeld;
  logic       wHeld;
  logic [9:0] wrIndex;
  logic [7:0] wrByte;
  logic       wrLaneOn;
  logic       wrEn;
  logic [9:0] rdIndex;
  // Fault synchronisers
  logic [3:0] faultMeta;
  logic [3:0] faultSync;
  logic       hpShortL;
  logic       hpShortR;
  logic       spkShort;
  logic       overTemp;
  logic [2:0] stageOn;
  logic [2:0] stageOnLast;

  odfc_step_if stepBus ();

  function automatic logic isMapped(input logic [9:0] idx);
    isMapped = idx == odfc_pkg::IDX_SW_RESET || idx == odfc_pkg::IDX_OTP
            || idx == odfc_pkg::IDX_STEP     || idx == odfc_pkg::IDX_HP_CTRL
            || idx == odfc_pkg::IDX_SPK_CTRL || idx == odfc_pkg::IDX_ROUTE
            || idx == odfc_pkg::IDX_SPK_VOL  || idx == odfc_pkg::IDX_HPL_GAIN
            || idx == odfc_pkg::IDX_HPR_GAIN || idx == odfc_pkg::IDX_SPK_GAIN
            || idx == odfc_pkg::IDX_DRIVE;
  endfunction : isMapped

  function automatic logic isWrite(input logic [9:0] idx, input logic [9:0] want);
    isWrite = wrEn && wrLaneOn && idx == want;
  endfunction : isWrite

  // Write happens once both halves are held
  assign wrEn     = awHeld && wHeld && !s_axi_bvalid;
  assign regReset = rst || softReset;
  assign hpShortL = faultSync[0];
  assign hpShortR = faultSync[1];
  assign spkShort = faultSync[2];
  assign overTemp = faultSync[3];

  // Address and data may arrive in either order
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      awHeld        <= 1'b0;
      s_axi_awready <= 1'b1;
      wrIndex       <= 10'h000;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      awHeld        <= 1'b1;
      s_axi_awready <= 1'b0;
      wrIndex       <= s_axi_awaddr[11:2];
    end
    else if (wrEn)
      awHeld <= 1'b0;
    else if (s_axi_bvalid && s_axi_bready)
      s_axi_awready <= 1'b1;
  end

  // Only the low byte lane carries register data
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wHeld        <= 1'b0;
      s_axi_wready <= 1'b1;
      wrByte       <= 8'h00;
      wrLaneOn     <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      wHeld        <= 1'b1;
      s_axi_wready <= 1'b0;
      wrByte       <= s_axi_wdata[7:0];
      wrLaneOn     <= s_axi_wstrb[0];
    end
    else if (wrEn)
      wHeld <= 1'b0;
    else if (s_axi_bvalid && s_axi_bready)
      s_axi_wready <= 1'b1;
  end

  // Write response; unmapped addresses answer SLVERR
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= odfc_pkg::RESP_OKAY;
    end
    else if (wrEn)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= isMapped(wrIndex) ? odfc_pkg::RESP_OKAY : odfc_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Read channel, one cycle to answer
  assign rdIndex = s_axi_araddr[11:2];
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= odfc_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= isMapped(rdIndex) ? odfc_pkg::RESP_OKAY : odfc_pkg::RESP_SLVERR;
      case (rdIndex)
        odfc_pkg::IDX_OTP:      s_axi_rdata <= {30'h0, overTemp, 1'b0};
        odfc_pkg::IDX_STEP:     s_axi_rdata <= {24'h0, stepReg};
        odfc_pkg::IDX_HP_CTRL:  s_axi_rdata <= {24'h0, hpCtrl};
        odfc_pkg::IDX_SPK_CTRL: s_axi_rdata <= {24'h0, spkCtrl};
        odfc_pkg::IDX_ROUTE:    s_axi_rdata <= {24'h0, routeReg};
        odfc_pkg::IDX_SPK_VOL:  s_axi_rdata <= {24'h0, spkVol};
        odfc_pkg::IDX_HPL_GAIN: s_axi_rdata <= {24'h0, hplGainReg};
        odfc_pkg::IDX_HPR_GAIN: s_axi_rdata <= {24'h0, hprGainReg};
        odfc_pkg::IDX_SPK_GAIN: s_axi_rdata <= {24'h0, spkGainReg};
        odfc_pkg::IDX_DRIVE:    s_axi_rdata <= {24'h0, driveReg};
        default:                s_axi_rdata <= 32'h0000_0000;
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Software master reset, one-cycle pulse
  always_ff @(posedge clk)
  begin
    if (rst)
      softReset <= 1'b0;
    else
      softReset <= isWrite(wrIndex, odfc_pkg::IDX_SW_RESET) && wrByte[0];
  end

  // Two flops before any detector level is used
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      faultMeta <= 4'h0;
      faultSync <= 4'h0;
    end
    else
    begin
      faultMeta <= {overTempIn, speakerShortIn, rightHpShortIn, leftHpShortIn};
      faultSync <= faultMeta;
    end
  end

  // Plain configuration registers
  always_ff @(posedge clk)
  begin
    if (regReset)
    begin
      stepReg    <= odfc_pkg::RST_DEFAULT;
      routeReg   <= odfc_pkg::RST_DEFAULT;
      spkVol     <= odfc_pkg::RST_SPK_VOL;
      hplGainReg <= odfc_pkg::RST_DEFAULT;
      hprGainReg <= odfc_pkg::RST_DEFAULT;
      spkGainReg <= odfc_pkg::RST_DEFAULT;
      driveReg   <= odfc_pkg::RST_DEFAULT;
    end
    else
    begin
      if (isWrite(wrIndex, odfc_pkg::IDX_STEP))     stepReg    <= {6'h00, wrByte[1:0]};
      if (isWrite(wrIndex, odfc_pkg::IDX_ROUTE))    routeReg   <= wrByte & 8'h44;
      if (isWrite(wrIndex, odfc_pkg::IDX_SPK_VOL))  spkVol     <= wrByte;
      if (isWrite(wrIndex, odfc_pkg::IDX_HPL_GAIN)) hplGainReg <= wrByte & 8'h7c;
      if (isWrite(wrIndex, odfc_pkg::IDX_HPR_GAIN)) hprGainReg <= wrByte & 8'h7c;
      if (isWrite(wrIndex, odfc_pkg::IDX_SPK_GAIN)) spkGainReg <= wrByte & 8'h1c;
      if (isWrite(wrIndex, odfc_pkg::IDX_DRIVE))    driveReg   <= wrByte & 8'h06;
    end
  end

  // Headphone control; a detected short beats a same-cycle write
  always_ff @(posedge clk)
  begin
    if (regReset)
      hpCtrl <= odfc_pkg::RST_DEFAULT;
    else
    begin
      if (isWrite(wrIndex, odfc_pkg::IDX_HP_CTRL))
      begin
        hpCtrl[7:1] <= {wrByte[7:3], 1'b0, wrByte[1]};
        if (wrByte[odfc_pkg::BIT_LEFT_EN] || wrByte[odfc_pkg::BIT_RIGHT_EN])
          hpCtrl[odfc_pkg::BIT_STATUS] <= 1'b0;
      end
      if (hpShortL || hpShortR)
        hpCtrl[odfc_pkg::BIT_STATUS] <= 1'b1;
      if (hpCtrl[odfc_pkg::BIT_SC_MODE] && hpShortL)
        hpCtrl[odfc_pkg::BIT_LEFT_EN] <= 1'b0;
      if (hpCtrl[odfc_pkg::BIT_SC_MODE] && hpShortR)
        hpCtrl[odfc_pkg::BIT_RIGHT_EN] <= 1'b0;
    end
  end

  // Speaker control; overcurrent always shuts down, no limit mode
  always_ff @(posedge clk)
  begin
    if (regReset)
      spkCtrl <= odfc_pkg::RST_DEFAULT;
    else
    begin
      if (isWrite(wrIndex, odfc_pkg::IDX_SPK_CTRL))
      begin
        spkCtrl[odfc_pkg::BIT_SPK_EN] <= wrByte[odfc_pkg::BIT_SPK_EN];
        if (wrByte[odfc_pkg::BIT_SPK_EN])
          spkCtrl[odfc_pkg::BIT_STATUS] <= 1'b0;
      end
      if (spkShort)
      begin
        spkCtrl[odfc_pkg::BIT_SPK_EN] <= 1'b0;
        spkCtrl[odfc_pkg::BIT_STATUS] <= 1'b1;
      end
    end
  end

  // Output flops derived from state
  always_ff @(posedge clk)
  begin
    if (regReset)
    begin
      speakerSwitchEn <= 1'b0;
      hpCurrentLimit  <= 1'b0;
      speakerVolMute  <= 1'b1;
      lineoutLowPower <= 1'b0;
    end
    else
    begin
      speakerSwitchEn <= spkCtrl[odfc_pkg::BIT_SPK_EN] && !overTemp && !spkShort;
      hpCurrentLimit  <= (hpShortL || hpShortR) && !hpCtrl[odfc_pkg::BIT_SC_MODE];
      speakerVolMute  <= !spkVol[odfc_pkg::BIT_VOL_ROUTE]
                         && spkVol[6:0] == odfc_pkg::ATTEN_MUTE;
      lineoutLowPower <= driveReg[odfc_pkg::DRIVE_LSB +: 2]
                         == odfc_pkg::DRIVE_LINEOUT;
    end
  end

  // Soft-start timers, one per stage; stages are independent
  assign stageOn = {spkCtrl[odfc_pkg::BIT_SPK_EN], hpCtrl[odfc_pkg::BIT_RIGHT_EN],
                    hpCtrl[odfc_pkg::BIT_LEFT_EN]};
  always_ff @(posedge clk)
  begin
    if (regReset)
      stageOnLast <= 3'h0;
    else
      stageOnLast <= stageOn;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_soft
      logic [7:0] ramp;
      always_ff @(posedge clk)
      begin
        if (regReset)
          ramp <= 8'h00;
        else if (stageOn[gi] && !stageOnLast[gi])
          ramp <= odfc_pkg::SOFTSTART_CYC;
        else if (!stageOn[gi])
          ramp <= 8'h00;
        else if (ramp != 8'h00)
          ramp <= ramp - 8'h01;
      end
      assign softStartActive[gi] = ramp != 8'h00;
    end
  endgenerate

  // Speaker volume soft-stepper
  assign stepBus.target = spkVol[6:0];
  assign stepBus.pace   = odfc_pkg::odfc_step_t'(stepReg[1:0]);
  odfc_soft_stepper u_stepper (
    .clk (clk),
    .rst (regReset),
    .stp (stepBus)
  );

  // Outputs straight from register bits
  assign leftHeadphoneOutOn  = hpCtrl[odfc_pkg::BIT_LEFT_EN];
  assign rightHeadphoneOutOn = hpCtrl[odfc_pkg::BIT_RIGHT_EN];
  assign speakerOutOn        = spkCtrl[odfc_pkg::BIT_SPK_EN];
  assign commonModeSel       = hpCtrl[odfc_pkg::CM_LSB +: 2];
  assign dacLeftToVolume     = routeReg[odfc_pkg::BIT_ROUTE_L];
  assign dacRightToVolume    = routeReg[odfc_pkg::BIT_ROUTE_R];
  assign speakerVolToAmp     = spkVol[odfc_pkg::BIT_VOL_ROUTE];
  assign speakerAtten        = stepBus.current;
  assign leftHpGain          = hplGainReg[odfc_pkg::GAIN_LSB +: 4];
  assign leftHpMute          = !hplGainReg[odfc_pkg::BIT_UNMUTE];
  assign rightHpGain         = hprGainReg[odfc_pkg::GAIN_LSB +: 4];
  assign rightHpMute         = !hprGainReg[odfc_pkg::BIT_UNMUTE];
  assign speakerGain         = spkGainReg[odfc_pkg::GAIN_LSB +: 2];
  assign speakerMute         = !spkGainReg[odfc_pkg::BIT_UNMUTE];

  default clocking cb @(posedge clk); endclocking
  default disable iff (regReset);

  property p_hp_shutdown;
    hpShortL && hpCtrl[odfc_pkg::BIT_SC_MODE] |=> !leftHeadphoneOutOn;
  endproperty
  a_hp_shutdown: assert property (p_hp_shutdown) else $error("left not shut down");

  property p_hp_limit;
    hpShortR && !hpCtrl[odfc_pkg::BIT_SC_MODE] |=> hpCurrentLimit;
  endproperty
  a_hp_limit: assert property (p_hp_limit) else $error("current limit missing");

  property p_hp_status;
    hpShortL || hpShortR |=> hpCtrl[odfc_pkg::BIT_STATUS];
  endproperty
  a_hp_status: assert property (p_hp_status) else $error("hp status not set");

  property p_spk_shut;
    spkShort |=> !speakerOutOn && spkCtrl[odfc_pkg::BIT_STATUS] ##1 !speakerSwitchEn;
  endproperty
  a_spk_shut: assert property (p_spk_shut) else $error("speaker not shut down");

  property p_spk_rearm;
    isWrite(wrIndex, odfc_pkg::IDX_SPK_CTRL) && wrByte[odfc_pkg::BIT_SPK_EN] && !spkShort
      |=> speakerOutOn && !spkCtrl[odfc_pkg::BIT_STATUS];
  endproperty
  a_spk_rearm: assert property (p_spk_rearm) else $error("speaker not re-armed");

  property p_otp;
    overTemp |=> !speakerSwitchEn;
  endproperty
  a_otp: assert property (p_otp) else $error("switching during overheat");

  property p_otp_resume;
    speakerOutOn && !overTemp && !spkShort |=> speakerSwitchEn;
  endproperty
  a_otp_resume: assert property (p_otp_resume) else $error("switching not resumed");

  property p_sync_delay;
    $rose(hpCtrl[odfc_pkg::BIT_STATUS]) |-> $past(leftHpShortIn || rightHpShortIn, 3);
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("status bypassed sync");

  property p_soft_start;
    $rose(leftHeadphoneOutOn) |-> ##1 softStartActive[0] [*8];
  endproperty
  a_soft_start: assert property (p_soft_start) else $error("no soft start");

  property p_vol_mute;
    !speakerVolToAmp && spkVol[6:0] == odfc_pkg::ATTEN_MUTE && $stable(spkVol)
      |=> speakerVolMute;
  endproperty
  a_vol_mute: assert property (p_vol_mute) else $error("volume not muted");

  c_hp_short:  cover property (hpShortL && hpCtrl[odfc_pkg::BIT_SC_MODE] ##1 !leftHeadphoneOutOn);
  c_spk_rearm: cover property (spkCtrl[odfc_pkg::BIT_STATUS] ##[1:50] speakerOutOn);
  c_otp:       cover property (speakerOutOn && overTemp ##[1:50] speakerSwitchEn);
  c_all_on:    cover property (&stageOn);

endmodule : odfc_output_driver_fault_control

// *** tb/odfc_output_driver_fault_control_tb_top.sv ***
// Self-checking bench for the output driver fault control block.
// Assumes odfc_pkg and the design files are compiled first; one 20 MHz clock.
`timescale 1ns/10ps
`define CHK(n, e, g) begin testsRun++; if ((g) !== (e)) begin failCount++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module odfc_output_driver_fault_control_tb_top;
  logic        clk = 1'b0, rst = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h1;
  logic [1:0]  s_axi_bresp, s_axi_rresp, commonModeSel, speakerGain;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        leftHpShortIn = 1'b0, rightHpShortIn = 1'b0;
  logic        speakerShortIn = 1'b0, overTempIn = 1'b0;
  logic        leftHeadphoneOutOn, rightHeadphoneOutOn, speakerOutOn, speakerSwitchEn;
  logic        hpCurrentLimit, lineoutLowPower, dacLeftToVolume, dacRightToVolume;
  logic        speakerVolToAmp, speakerVolMute, leftHpMute, rightHpMute, speakerMute;
  logic [2:0]  softStartActive;
  logic [6:0]  speakerAtten;
  logic [3:0]  leftHpGain, rightHpGain;
  int          failCount = 0, testsRun = 0, cycles = 0;

  odfc_output_driver_fault_control u_odfc_output_driver_fault_control (
    .clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .leftHpShortIn, .rightHpShortIn, .speakerShortIn, .overTempIn, .leftHeadphoneOutOn,
    .rightHeadphoneOutOn, .speakerOutOn, .speakerSwitchEn, .hpCurrentLimit, .softStartActive,
    .commonModeSel, .lineoutLowPower, .dacLeftToVolume, .dacRightToVolume, .speakerVolToAmp,
    .speakerAtten, .speakerVolMute, .leftHpGain, .leftHpMute, .rightHpGain, .rightHpMute,
    .speakerGain, .speakerMute);

  // Free-running system clock
  initial
  begin
    forever #25 clk = ~clk;
  end

  // Hang guard, well above the longest soft-step wait
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failCount++;
      endSim();
    end
  end

  // Write one register; address and data offered together, released once taken
  task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic a;
    logic w;
    a = 1'b0;
    w = 1'b0;
    s_axi_awaddr  <= {idx, 2'b00};
    s_axi_wdata   <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(a && w))
    begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      a = a | s_axi_awready;
      w = w | s_axi_wready;
    end
    do @(posedge clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    `CHK("bresp", er, s_axi_bresp)
    @(posedge clk); // Gap edge: next call never re-drives bready in this step
  endtask : wr

  // Read one register and compare the whole word (upper bytes zero) and response
  task automatic rd(input logic [9:0] idx, input logic [7:0] e, input logic [1:0] er);
    s_axi_araddr  <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    `CHK("rdata", {24'h0, e}, s_axi_rdata)
    `CHK("rresp", er, s_axi_rresp)
    @(posedge clk); // Gap edge: next call never re-drives rready in this step
  endtask : rd

  // Verdict and end of run
  task automatic endSim;
    $display("Counts: %0d compared, %0d mismatched", testsRun, failCount);
    if (failCount == 0 && testsRun > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : endSim

  // Test sequence; fault inputs need three edges to act, so five are allowed
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(odfc_pkg::IDX_SPK_VOL, 8'h7f, odfc_pkg::RESP_OKAY);
    `CHK("volMute", 1'b1, speakerVolMute)
    wr(odfc_pkg::IDX_HP_CTRL, 8'hd2, odfc_pkg::RESP_OKAY);
    `CHK("cm", 2'h2, commonModeSel)
    wr(odfc_pkg::IDX_HPL_GAIN, 8'h4c, odfc_pkg::RESP_OKAY);
    wr(odfc_pkg::IDX_HPR_GAIN, 8'h78, odfc_pkg::RESP_OKAY);
    `CHK("hpGain", {4'h9, 1'b0, 4'hf, 1'b1}, {leftHpGain, leftHpMute, rightHpGain, rightHpMute})
    `CHK("soft", 3'h3, softStartActive)
    leftHpShortIn <= 1'b1;
    repeat (5) @(posedge clk);
    `CHK("hpOn", 2'b01, {leftHeadphoneOutOn, rightHeadphoneOutOn})
    rd(odfc_pkg::IDX_HP_CTRL, 8'h53, odfc_pkg::RESP_OKAY);
    leftHpShortIn <= 1'b0;
    repeat (5) @(posedge clk);
    wr(odfc_pkg::IDX_HP_CTRL, 8'hd2, odfc_pkg::RESP_OKAY);
    rd(odfc_pkg::IDX_HP_CTRL, 8'hd2, odfc_pkg::RESP_OKAY);
    wr(odfc_pkg::IDX_HP_CTRL, 8'hc0, odfc_pkg::RESP_OKAY);
    rightHpShortIn <= 1'b1;
    repeat (5) @(posedge clk);
    `CHK("limit", 2'b11, {hpCurrentLimit, rightHeadphoneOutOn})
    rightHpShortIn <= 1'b0;
    $display("test headphone done");
    wr(odfc_pkg::IDX_SPK_CTRL, 8'h80, odfc_pkg::RESP_OKAY);
    repeat (5) @(posedge clk);
    `CHK("spkOn", 3'b111, {speakerOutOn, speakerSwitchEn, softStartActive[2]})
    overTempIn <= 1'b1;
    repeat (5) @(posedge clk);
    `CHK("otSw", 1'b0, speakerSwitchEn)
    rd(odfc_pkg::IDX_OTP, 8'h02, odfc_pkg::RESP_OKAY);
    overTempIn <= 1'b0;
    repeat (5) @(posedge clk);
    `CHK("cool", 1'b1, speakerSwitchEn)
    speakerShortIn <= 1'b1;
    repeat (5) @(posedge clk);
    `CHK("spkShut", 1'b0, speakerOutOn)
    rd(odfc_pkg::IDX_SPK_CTRL, 8'h01, odfc_pkg::RESP_OKAY);
    wr(odfc_pkg::IDX_SPK_CTRL, 8'h80, odfc_pkg::RESP_OKAY);
    repeat (5) @(posedge clk);
    `CHK("reShut", 1'b0, speakerOutOn)
    speakerShortIn <= 1'b0;
    repeat (5) @(posedge clk);
    // Second and last re-arm attempt, short now released
    wr(odfc_pkg::IDX_SPK_CTRL, 8'h80, odfc_pkg::RESP_OKAY);
    `CHK("reArm", 1'b1, speakerOutOn)
    $display("test speaker done");
    wr(odfc_pkg::IDX_ROUTE, 8'h40, odfc_pkg::RESP_OKAY);
    `CHK("route", 2'b10, {dacLeftToVolume, dacRightToVolume})
    wr(odfc_pkg::IDX_SPK_GAIN, 8'h14, odfc_pkg::RESP_OKAY);
    `CHK("spkGain", 3'b100, {speakerGain, speakerMute})
    wr(odfc_pkg::IDX_DRIVE, 8'h06, odfc_pkg::RESP_OKAY);
    `CHK("lineout", 1'b1, lineoutLowPower)
    wr(odfc_pkg::IDX_DRIVE, 8'h04, odfc_pkg::RESP_OKAY);
    `CHK("lineout2", 1'b0, lineoutLowPower)
    wr(odfc_pkg::IDX_STEP, 8'h02, odfc_pkg::RESP_OKAY);
    wr(odfc_pkg::IDX_SPK_VOL, 8'h85, odfc_pkg::RESP_OKAY);
    repeat (5) @(posedge clk);
    `CHK("vol", 9'h105, {speakerVolToAmp, speakerVolMute, speakerAtten})
    // Paced stepping: one code per 417 cycles, first step 417 after the write
    wr(odfc_pkg::IDX_STEP, 8'h00, odfc_pkg::RESP_OKAY);
    wr(odfc_pkg::IDX_SPK_VOL, 8'h87, odfc_pkg::RESP_OKAY);
    repeat (300) @(posedge clk);
    `CHK("paced", 7'h05, speakerAtten)
    repeat (300) @(posedge clk);
    `CHK("stepMid", 7'h06, speakerAtten)
    repeat (400) @(posedge clk);
    `CHK("stepEnd", 7'h07, speakerAtten)
    // Slow pacing: one code per 833 cycles
    wr(odfc_pkg::IDX_STEP, 8'h01, odfc_pkg::RESP_OKAY);
    wr(odfc_pkg::IDX_SPK_VOL, 8'h88, odfc_pkg::RESP_OKAY);
    repeat (500) @(posedge clk);
    `CHK("slowHold", 7'h07, speakerAtten)
    repeat (400) @(posedge clk);
    `CHK("slowStep", 7'h08, speakerAtten)
    wr(odfc_pkg::IDX_SPK_VOL, 8'h7f, odfc_pkg::RESP_OKAY);
    repeat (3) @(posedge clk);
    `CHK("mute", 2'b01, {speakerVolToAmp, speakerVolMute})
    wr(10'h002, 8'h55, odfc_pkg::RESP_SLVERR);
    rd(10'h002, 8'h00, odfc_pkg::RESP_SLVERR);
    wr(odfc_pkg::IDX_SW_RESET, 8'h01, odfc_pkg::RESP_OKAY);
    repeat (3) @(posedge clk);
    `CHK("swRst", 5'h00, {leftHpGain, speakerOutOn})
    $display("test routing and reset done");
    endSim();
  end
endmodule : odfc_output_driver_fault_control_tb_top
